// [mcbec_encoder.sv]
// Bank error code encoder with its APB register slave.
`timescale 1ns/1ps

// How it works
// RQ1 - Cache error: outcome 18:16, fixed pattern above
// RQ2 - Outcomes 000-011: none, multi-way events
// RQ3 - Outcomes 100-111: none, single way, mixed
// RQ4 - Bus request parity bit16, response bit20
// RQ5 - Core address parity bits 17, 18
// RQ6 - Data parity bits 21, 22, 23
// RQ7 - Enhanced defer parity sets bit 24
// RQ8 - Inbound data ECC sets bit 25
// RQ9 - Strobe glitch bits 26, 27; top reserved
// RQ10 - Exactly one bus flag per report
// RQ11 - Bus ECC correctability via uncorrected flag
// RQ12 - Other bus errors are uncorrectable
// RQ13 - Core inclusion and write-exclusive codes 1-4
// RQ14 - Bus inclusion, probe stall, write stall codes
// RQ15 - Arbitration timeout 8, queue fault 9
// RQ16 - Internal timeout codes 0200 or 0300
// RQ17 - Thermal 0100, safety queue 0400
// RQ18 - Correctable outgoing ECC codes c001-c004
// RQ19 - Uncorrectable outgoing ECC codes e001-e004
// RQ20 - Controller codes uncorrectable except correctable ECC
// RQ21 - Controller correctable ECC may carry syndrome
// RQ22 - Model-specific code sits in 31:16
// RQ23 - Type code in 15:0 per kind
// RQ24 - Syndrome in 51:44, valid bit 52
// RQ25 - Whole record updated in one write
module mcbec_encoder (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire mcbec_pkg::mcbec_apb_req_t apb_req,
	output mcbec_pkg::mcbec_apb_rsp_t     apb_rsp,
	input  wire mcbec_pkg::mcbec_event_t  err_event,
	output logic                          err_logged,
	output logic                          err_dropped
);
	import mcbec_pkg::*;

	// ----------------------------------------
	// Code construction
	// ----------------------------------------
	function automatic logic [15:0] cbc_code(input logic [4:0] idx);
		logic [15:0] c;
		c = 16'h0000;
		case (idx)
			5'h00: c = CBC_INCL_C0; // RQ13
			5'h01: c = CBC_INCL_C1;
			5'h02: c = CBC_WEXC_C0;
			5'h03: c = CBC_WEXC_C1;
			5'h04: c = CBC_INCL_BUS; // RQ14
			5'h05: c = CBC_PROBE_ST;
			5'h06: c = CBC_WR_STALL;
			5'h07: c = CBC_ARB_TO; // RQ15
			5'h08: c = CBC_OOQ;
			5'h09: c = CBC_THERMAL; // RQ17
			5'h0a: c = CBC_INT_TO_A; // RQ16
			5'h0b: c = CBC_INT_TO_B;
			5'h0c: c = CBC_SAFE_Q;
			5'h0d: c = CBC_CE_BUS; // RQ18
			5'h0e: c = CBC_CE_C0;
			5'h0f: c = CBC_CE_C1;
			5'h10: c = CBC_UE_BUS; // RQ19
			5'h11: c = CBC_UE_C0;
			5'h12: c = CBC_UE_C1;
			default: c = 16'h0000;
		endcase
		return c;
	endfunction

	function automatic logic cbc_correctable(input logic [4:0] idx);
		return (idx >= 5'h0d) && (idx <= 5'h0f); // RQ20
	endfunction

	// A bus flag index that points at a reserved bit cannot be encoded.
	function automatic logic bus_index_ok(input logic [3:0] idx);
		logic [15:0] onehot;
		onehot = 16'h0001 << idx;
		return (onehot & BUS_DEFINED_MASK) != 16'h0000;
	endfunction

	wire logic [15:0] bus_onehot  = 16'h0001 << err_event.bus_index; // RQ10
	wire logic [15:0] llc_model_specific_error_field    = {LLC_PATTERN, 2'b00, err_event.llc_outcome}; // RQ1 RQ2 RQ3
	wire logic [15:0] cbc_model_specific_error_field    = cbc_code(err_event.cbc_index);
	wire logic        bus_is_ecc  = err_event.bus_index == 4'(BUS_ECC);
	wire logic        cbc_ok      = cbc_model_specific_error_field != 16'h0000; // RQ20
	wire logic        bus_ok      = bus_index_ok(err_event.bus_index);
	wire logic        bus_uc      = !(bus_is_ecc && err_event.synd_valid); // RQ11 RQ12
	wire logic        cbc_uc      = !cbc_correctable(err_event.cbc_index);
	wire logic        synd_use    = err_event.synd_valid &&
		((err_event.kind == MCBEC_KIND_BUS && bus_is_ecc) ||
		 (err_event.kind == MCBEC_KIND_CBC && !cbc_uc)); // RQ21 RQ24

	logic [15:0] sel_type;
	logic [15:0] sel_model_specific_error_field;
	logic        sel_uc;
	logic        sel_ok;

	always_comb begin
		sel_type = 16'h0000;
		sel_model_specific_error_field = 16'h0000;
		sel_uc   = 1'b0;
		sel_ok   = 1'b0;
		case (err_event.kind)
			MCBEC_KIND_LLC: begin
				sel_type = TYPE_A_CODE; // RQ23
				sel_model_specific_error_field = llc_model_specific_error_field;
				sel_uc   = err_event.llc_outcome[1];
				sel_ok   = 1'b1;
			end
			MCBEC_KIND_BUS: begin
				sel_type = TYPE_B_CODE;
				sel_model_specific_error_field = bus_onehot; // RQ4 RQ5 RQ6 RQ7 RQ8 RQ9
				sel_uc   = bus_uc;
				sel_ok   = bus_ok;
			end
			MCBEC_KIND_CBC: begin
				sel_type = TYPE_C_CODE;
				sel_model_specific_error_field = cbc_model_specific_error_field;
				sel_uc   = cbc_uc;
				sel_ok   = cbc_ok;
			end
			default: begin
				sel_ok = 1'b0;
			end
		endcase
	end

	// The record is written whole; an event that hits a record which is still valid is dropped,
	// so software never sees a first error replaced under its feet.
	logic [63:0] status;
	logic [31:0] ctrl;
	wire logic        bank_valid = status[POS_VAL];
	wire logic        log_now    = err_event.valid && sel_ok && !bank_valid && ctrl[0];
	wire logic [63:0] new_record = {1'b1, 1'b0, sel_uc, 8'h00, synd_use,
		(synd_use ? err_event.syndrome : 8'h00), 12'h000, sel_model_specific_error_field, sel_type}; // RQ22 RQ24 RQ25

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	wire logic apb_access = apb_req.psel && apb_req.penable;
	wire logic apb_wr     = apb_access && apb_req.pwrite;
	wire logic hit_lo     = apb_req.paddr == OFS_STATUS_LO;
	wire logic hit_hi     = apb_req.paddr == OFS_STATUS_HI;
	wire logic hit_ctrl   = apb_req.paddr == OFS_CTRL;
	wire logic hit_evt    = apb_req.paddr == OFS_EVENT;
	wire logic hit_any    = hit_lo || hit_hi || hit_ctrl || hit_evt;
	wire logic clr_hi     = apb_wr && hit_hi;
	wire logic wr_lo      = apb_wr && hit_lo;
	wire logic wr_ctrl    = apb_wr && hit_ctrl;

	logic [31:0] evt_count;

	wire logic [31:0] rd_mux = hit_lo   ? status[31:0]  :
	                           hit_hi   ? status[63:32] :
	                           hit_ctrl ? ctrl          :
	                           hit_evt  ? evt_count     : 32'h0000_0000;

	wire logic [63:0] next_status = log_now ? new_record :
	                                clr_hi  ? {apb_req.pwdata, status[31:0]} :
	                                wr_lo   ? {status[63:32], apb_req.pwdata} : status;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status      <= STATUS_RESET;
			ctrl        <= CTRL_RESET;
			evt_count   <= 32'h0000_0000;
			err_logged  <= 1'b0;
			err_dropped <= 1'b0;
			apb_rsp     <= '0;
		end else begin
			status      <= next_status; // RQ25
			ctrl        <= wr_ctrl ? apb_req.pwdata : ctrl;
			evt_count   <= log_now ? evt_count + 32'h0000_0001 : evt_count;
			err_logged  <= log_now;
			err_dropped <= err_event.valid && !log_now;
			apb_rsp.pready  <= apb_req.psel && !apb_req.penable;
			apb_rsp.pslverr <= apb_req.psel && !apb_req.penable && !hit_any;
			apb_rsp.prdata  <= (apb_req.psel && !apb_req.penable && !apb_req.pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	wire logic log_llc = log_now && err_event.kind == MCBEC_KIND_LLC;
	wire logic log_bus = log_now && err_event.kind == MCBEC_KIND_BUS;
	wire logic log_cbc = log_now && err_event.kind == MCBEC_KIND_CBC;

	property p_llc_pattern;
		@(posedge pclk) disable iff (!presetn)
		(log_now && err_event.kind == MCBEC_KIND_LLC) |=>
			status[31:21] == LLC_PATTERN && status[20:19] == 2'b00 && status[15:0] == TYPE_A_CODE;
	endproperty
	a_llc_pattern: assert property (p_llc_pattern) else $error("Cache error record malformed."); // RQ1

	property p_llc_outcome;
		@(posedge pclk) disable iff (!presetn)
		(log_now && err_event.kind == MCBEC_KIND_LLC) |=> status[18:16] == $past(err_event.llc_outcome);
	endproperty
	a_llc_outcome: assert property (p_llc_outcome) else $error("Cache outcome code lost."); // RQ2

	property p_bus_onehot;
		@(posedge pclk) disable iff (!presetn)
		(log_now && err_event.kind == MCBEC_KIND_BUS) |=>
			$onehot(status[31:16]) && (status[31:16] & ~BUS_DEFINED_MASK) == 16'h0000;
	endproperty
	a_bus_onehot: assert property (p_bus_onehot) else $error("Bus flags not exactly one."); // RQ10

	property p_bus_uc;
		@(posedge pclk) disable iff (!presetn)
		(log_now && err_event.kind == MCBEC_KIND_BUS && !bus_is_ecc) |=> status[POS_UC];
	endproperty
	a_bus_uc: assert property (p_bus_uc) else $error("Bus error not uncorrectable."); // RQ12

	property p_cbc_uc;
		@(posedge pclk) disable iff (!presetn)
		(log_now && err_event.kind == MCBEC_KIND_CBC) |=>
			status[POS_UC] == !(status[31:29] == 3'b110);
	endproperty
	a_cbc_uc: assert property (p_cbc_uc) else $error("Controller correctability wrong."); // RQ20

	property p_cbc_code;
		@(posedge pclk) disable iff (!presetn)
		(log_now && err_event.kind == MCBEC_KIND_CBC && err_event.cbc_index == 5'h07) |=>
			status[31:16] == 16'h0008 && status[15:0] == TYPE_C_CODE;
	endproperty
	a_cbc_code: assert property (p_cbc_code) else $error("Arbitration timeout code wrong."); // RQ15

	property p_synd;
		@(posedge pclk) disable iff (!presetn)
		log_now |=> status[POS_SYNDV] == $past(synd_use) &&
			(!status[POS_SYNDV] || status[51:44] == $past(err_event.syndrome));
	endproperty
	a_synd: assert property (p_synd) else $error("Syndrome field wrong."); // RQ24

	property p_single_update;
		@(posedge pclk) disable iff (!presetn)
		$rose(status[POS_VAL]) |-> $past(log_now) && status[15:0] != 16'h0000;
	endproperty
	a_single_update: assert property (p_single_update) else $error("Record not written whole."); // RQ25

	property p_llc_multi;
		@(posedge pclk) disable iff (!presetn)
		(log_llc && !err_event.llc_outcome[2]) |=> !status[18];
	endproperty
	a_llc_multi: assert property (p_llc_multi) else $error("Multi-way outcome wrong."); // RQ2

	property p_llc_single;
		@(posedge pclk) disable iff (!presetn)
		(log_llc && err_event.llc_outcome[2]) |=> status[18];
	endproperty
	a_llc_single: assert property (p_llc_single) else $error("Single-way outcome wrong."); // RQ3

	property p_bus_req_par;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_REQ_PAR)) |=> status[31:16] == 16'h0001;
	endproperty
	a_bus_req_par: assert property (p_bus_req_par) else $error("Request parity flag wrong."); // RQ4

	property p_bus_rsp_par;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_RSP_PAR)) |=> status[31:16] == 16'h0010;
	endproperty
	a_bus_rsp_par: assert property (p_bus_rsp_par) else $error("Response parity flag wrong."); // RQ4

	property p_bus_c0_addr;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_C0_ADDR)) |=> status[31:16] == 16'h0002;
	endproperty
	a_bus_c0_addr: assert property (p_bus_c0_addr) else $error("Core 0 address flag wrong."); // RQ5

	property p_bus_c1_addr;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_C1_ADDR)) |=> status[31:16] == 16'h0004;
	endproperty
	a_bus_c1_addr: assert property (p_bus_c1_addr) else $error("Core 1 address flag wrong."); // RQ5

	property p_bus_data_par;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_DATA_PAR)) |=> status[31:16] == 16'h0020;
	endproperty
	a_bus_data_par: assert property (p_bus_data_par) else $error("Inbound data parity flag wrong."); // RQ6

	property p_bus_c0_data;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_C0_DATA)) |=> status[31:16] == 16'h0040;
	endproperty
	a_bus_c0_data: assert property (p_bus_c0_data) else $error("Core 0 data flag wrong."); // RQ6

	property p_bus_c1_data;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_C1_DATA)) |=> status[31:16] == 16'h0080;
	endproperty
	a_bus_c1_data: assert property (p_bus_c1_data) else $error("Core 1 data flag wrong."); // RQ6

	property p_bus_defer;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_DEFER_PAR)) |=> status[31:16] == 16'h0100;
	endproperty
	a_bus_defer: assert property (p_bus_defer) else $error("Defer parity flag wrong."); // RQ7

	property p_bus_ecc;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_ECC)) |=> status[31:16] == 16'h0200;
	endproperty
	a_bus_ecc: assert property (p_bus_ecc) else $error("Inbound ECC flag wrong."); // RQ8

	property p_bus_dstb;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_DSTB)) |=> status[31:16] == 16'h0400;
	endproperty
	a_bus_dstb: assert property (p_bus_dstb) else $error("Data strobe flag wrong."); // RQ9

	property p_bus_rstb;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && err_event.bus_index == 4'(BUS_RSTB)) |=> status[31:16] == 16'h0800;
	endproperty
	a_bus_rstb: assert property (p_bus_rstb) else $error("Request strobe flag wrong."); // RQ9

	property p_bus_ecc_uc;
		@(posedge pclk) disable iff (!presetn)
		(log_bus && bus_is_ecc) |=> status[POS_UC] == !$past(err_event.synd_valid);
	endproperty
	a_bus_ecc_uc: assert property (p_bus_ecc_uc) else $error("Bus ECC correctability wrong."); // RQ11

	property p_bus_type;
		@(posedge pclk) disable iff (!presetn)
		log_bus |=> status[15:0] == TYPE_B_CODE && status[43:32] == 12'h000;
	endproperty
	a_bus_type: assert property (p_bus_type) else $error("Bus type code wrong."); // RQ23

	property p_cbc_core;
		@(posedge pclk) disable iff (!presetn)
		(log_cbc && err_event.cbc_index < 5'h04) |=> status[31:16] == {11'h000, $past(err_event.cbc_index) + 5'h01};
	endproperty
	a_cbc_core: assert property (p_cbc_core) else $error("Core controller code wrong."); // RQ13

	property p_cbc_bus;
		@(posedge pclk) disable iff (!presetn)
		(log_cbc && err_event.cbc_index inside {[5'h04:5'h06]}) |=>
			status[31:16] == {11'h000, $past(err_event.cbc_index) + 5'h01};
	endproperty
	a_cbc_bus: assert property (p_cbc_bus) else $error("Bus controller code wrong."); // RQ14

	property p_cbc_int_to;
		@(posedge pclk) disable iff (!presetn)
		(log_cbc && err_event.cbc_index inside {5'h0a, 5'h0b}) |=>
			status[31:16] == ($past(err_event.cbc_index[0]) ? 16'h0300 : 16'h0200);
	endproperty
	a_cbc_int_to: assert property (p_cbc_int_to) else $error("Internal timeout code wrong."); // RQ16

	property p_cbc_thermal_safe;
		@(posedge pclk) disable iff (!presetn)
		(log_cbc && err_event.cbc_index inside {5'h09, 5'h0c}) |=>
			status[31:16] == ($past(err_event.cbc_index[2]) ? 16'h0400 : 16'h0100);
	endproperty
	a_cbc_thermal_safe: assert property (p_cbc_thermal_safe) else $error("Thermal or queue code wrong."); // RQ17

	property p_cbc_ce;
		@(posedge pclk) disable iff (!presetn)
		(log_cbc && err_event.cbc_index inside {[5'h0d:5'h0f]}) |=>
			status[31:19] == 13'h1800 && $onehot(status[18:16]) && !status[POS_UC];
	endproperty
	a_cbc_ce: assert property (p_cbc_ce) else $error("Correctable ECC code wrong."); // RQ18

	property p_cbc_ue;
		@(posedge pclk) disable iff (!presetn)
		(log_cbc && err_event.cbc_index inside {[5'h10:5'h12]}) |=>
			status[31:19] == 13'h1c00 && $onehot(status[18:16]) && status[POS_UC];
	endproperty
	a_cbc_ue: assert property (p_cbc_ue) else $error("Uncorrectable ECC code wrong."); // RQ19

	property p_cbc_reserved;
		@(posedge pclk) disable iff (!presetn)
		(err_event.valid && err_event.kind == MCBEC_KIND_CBC && err_event.cbc_index > 5'h12) |=>
			err_dropped && !err_logged;
	endproperty
	a_cbc_reserved: assert property (p_cbc_reserved) else $error("Reserved code not dropped."); // RQ20

	property p_cbc_synd;
		@(posedge pclk) disable iff (!presetn)
		(log_cbc && err_event.synd_valid && err_event.cbc_index inside {[5'h0d:5'h0f]}) |=> status[POS_SYNDV];
	endproperty
	a_cbc_synd: assert property (p_cbc_synd) else $error("Controller syndrome missing."); // RQ21

	property p_drop_busy;
		@(posedge pclk) disable iff (!presetn)
		(err_event.valid && status[POS_VAL]) |=> err_dropped && !err_logged;
	endproperty
	a_drop_busy: assert property (p_drop_busy) else $error("Valid record overwritten."); // RQ25

endmodule

// [mcbec_pkg.sv]
// Package with constants and types for the bank error code encoder.
package mcbec_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] OFS_STATUS_LO = 12'h000;
	localparam logic [11:0] OFS_STATUS_HI = 12'h004;
	localparam logic [11:0] OFS_CTRL      = 12'h008;
	localparam logic [11:0] OFS_EVENT     = 12'h00c;

	// ----------------------------------------
	// Status field positions and fixed values
	// ----------------------------------------
	localparam int          POS_MODEL_SPECIFIC_ERROR_FIELD       = 16;
	localparam int          POS_SYND       = 44;
	localparam int          POS_SYNDV      = 52;
	localparam int          POS_UC         = 61;
	localparam int          POS_VAL        = 63;
	localparam logic [10:0] LLC_PATTERN    = 11'h100;
	localparam logic [15:0] TYPE_A_CODE    = 16'h010b;
	localparam logic [15:0] TYPE_B_CODE    = 16'h0e0f;
	localparam logic [15:0] TYPE_C_CODE    = 16'h0400;
	localparam logic [63:0] STATUS_RESET   = 64'h0;
	localparam logic [31:0] CTRL_RESET     = 32'h0;

	// ----------------------------------------
	// Bus error flag positions within the model-specific field
	// ----------------------------------------
	localparam int BUS_REQ_PAR   = 0;
	localparam int BUS_C0_ADDR   = 1;
	localparam int BUS_C1_ADDR   = 2;
	localparam int BUS_RSP_PAR   = 4;
	localparam int BUS_DATA_PAR  = 5;
	localparam int BUS_C0_DATA   = 6;
	localparam int BUS_C1_DATA   = 7;
	localparam int BUS_DEFER_PAR = 8;
	localparam int BUS_ECC       = 9;
	localparam int BUS_DSTB      = 10;
	localparam int BUS_RSTB      = 11;
	localparam logic [15:0] BUS_DEFINED_MASK = 16'h0ff7;

	// ----------------------------------------
	// Cache bus controller codes
	// ----------------------------------------
	localparam logic [15:0] CBC_INCL_C0   = 16'h0001;
	localparam logic [15:0] CBC_INCL_C1   = 16'h0002;
	localparam logic [15:0] CBC_WEXC_C0   = 16'h0003;
	localparam logic [15:0] CBC_WEXC_C1   = 16'h0004;
	localparam logic [15:0] CBC_INCL_BUS  = 16'h0005;
	localparam logic [15:0] CBC_PROBE_ST  = 16'h0006;
	localparam logic [15:0] CBC_WR_STALL  = 16'h0007;
	localparam logic [15:0] CBC_ARB_TO    = 16'h0008;
	localparam logic [15:0] CBC_OOQ       = 16'h0009;
	localparam logic [15:0] CBC_THERMAL   = 16'h0100;
	localparam logic [15:0] CBC_INT_TO_A  = 16'h0200;
	localparam logic [15:0] CBC_INT_TO_B  = 16'h0300;
	localparam logic [15:0] CBC_SAFE_Q    = 16'h0400;
	localparam logic [15:0] CBC_CE_BUS    = 16'hc001;
	localparam logic [15:0] CBC_CE_C0     = 16'hc002;
	localparam logic [15:0] CBC_CE_C1     = 16'hc004;
	localparam logic [15:0] CBC_UE_BUS    = 16'he001;
	localparam logic [15:0] CBC_UE_C0     = 16'he002;
	localparam logic [15:0] CBC_UE_C1     = 16'he004;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MCBEC_KIND_NONE,
		MCBEC_KIND_LLC,
		MCBEC_KIND_BUS,
		MCBEC_KIND_CBC
	} mcbec_kind_t;

	typedef struct packed {
		logic        valid;
		mcbec_kind_t kind;
		logic [2:0]  llc_outcome;
		logic [3:0]  bus_index;
		logic [4:0]  cbc_index;
		logic        synd_valid;
		logic [7:0]  syndrome;
	} mcbec_event_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} mcbec_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} mcbec_apb_rsp_t;

endpackage

// [mcbec_testbench.sv]
// Self-checking testbench for the bank error code encoder.
`timescale 1ns/1ps
module testbench;
	import mcbec_pkg::*;
	// ----------------------------------------
	// Signals and bookkeeping
	// ----------------------------------------
	logic           pclk;
	logic           presetn;
	mcbec_apb_req_t apb_req;
	mcbec_apb_rsp_t apb_rsp;
	mcbec_event_t   err_event;
	logic           err_logged;
	logic           err_dropped;
	logic [32:0]    read_q[$];
	logic           event_q[$];
	int             n_mismatch;
	int             num_checks;
	int             cycles;
	int             n_logged;
	integer         seed;
	logic           sv;
	logic [7:0]     syn;
	logic [15:0]    codes[19];

	mcbec_encoder i_dut (
		.pclk       (pclk),
		.presetn    (presetn),
		.apb_req    (apb_req),
		.apb_rsp    (apb_rsp),
		.err_event  (err_event),
		.err_logged (err_logged),
		.err_dropped(err_dropped)
	);

	always #20 pclk = ~pclk;

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmp_read(input logic [32:0] exp, input logic [32:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t read exp %h got %h", $time, exp, got);
		end
	endtask

	task automatic cmp_event(input logic [1:0] exp, input logic [1:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t event exp %h got %h", $time, exp, got);
		end
	endtask

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data, input logic [32:0] exp);
		@(posedge pclk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= addr;
		apb_req.pwdata <= data;
		if (!wr) begin
			read_q.push_back(exp);
		end
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	// The syndrome is random so that a stuck or shifted syndrome field shows up.
	task automatic send(input mcbec_kind_t k, input int idx, input logic exp);
		mcbec_event_t ev;
		ev = '0;
		sv = 1'($random(seed));
		syn = 8'($random(seed));
		ev.valid = 1'b1;
		ev.kind = k;
		ev.llc_outcome = idx[2:0];
		ev.bus_index = idx[3:0];
		ev.cbc_index = idx[4:0];
		ev.synd_valid = sv;
		ev.syndrome = syn;
		@(posedge pclk);
		err_event <= ev;
		event_q.push_back(exp);
		n_logged += exp;
		@(posedge pclk);
		err_event.valid <= 1'b0;
		@(posedge pclk);
	endtask

	// Reads both status words, then clears the record so the next event is taken.
	task automatic check_rec(input logic [31:0] lo, input logic uc, input logic keep);
		logic [31:0] hi;
		hi = 32'h8000_0000 | (32'(uc) << (POS_UC - 32));
		if (keep) begin
			hi = hi | (32'h1 << (POS_SYNDV - 32)) | (32'(syn) << (POS_SYND - 32));
		end
		apb(1'b0, OFS_STATUS_LO, 32'h0, {1'b0, lo});
		apb(1'b0, OFS_STATUS_HI, 32'h0, {1'b0, hi});
		apb(1'b1, OFS_STATUS_HI, 32'h0, 33'h0);
	endtask

	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			n_mismatch++;
			stop_test();
		end
		if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && !apb_req.pwrite) begin
			cmp_read(read_q.size() > 0 ? read_q.pop_front() : 33'h0, {apb_rsp.pslverr, apb_rsp.prdata});
		end
		if (err_logged === 1'b1 || err_dropped === 1'b1) begin
			cmp_event(event_q.size() > 0 ? {event_q[0], !event_q[0]} : 2'b00, {err_logged, err_dropped});
			if (event_q.size() > 0) begin
				void'(event_q.pop_front());
			end
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		apb_req = '0;
		err_event = '0;
		seed = 32'hd6df610d;
		codes = '{CBC_INCL_C0, CBC_INCL_C1, CBC_WEXC_C0, CBC_WEXC_C1, CBC_INCL_BUS, CBC_PROBE_ST,
			CBC_WR_STALL, CBC_ARB_TO, CBC_OOQ, CBC_THERMAL, CBC_INT_TO_A, CBC_INT_TO_B, CBC_SAFE_Q,
			CBC_CE_BUS, CBC_CE_C0, CBC_CE_C1, CBC_UE_BUS, CBC_UE_C0, CBC_UE_C1};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_STATUS_LO, 32'h0, {1'b0, STATUS_RESET[31:0]});
		apb(1'b0, OFS_STATUS_HI, 32'h0, {1'b0, STATUS_RESET[63:32]});
		apb(1'b0, OFS_CTRL, 32'h0, {1'b0, CTRL_RESET});
		send(MCBEC_KIND_LLC, 5, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h1, 33'h0);
		apb(1'b0, OFS_CTRL, 32'h0, 33'h1);
		$display("test reset done");
		for (int o = 0; o < 8; o++) begin
			send(MCBEC_KIND_LLC, o, 1'b1);
			check_rec({LLC_PATTERN, 2'b00, 3'(o), TYPE_A_CODE}, o[1], 1'b0);
		end
		$display("test cache done");
		for (int i = 0; i < 16; i++) begin
			send(MCBEC_KIND_BUS, i, i < 12 && i != 3);
			if (i < 12 && i != 3) begin
				check_rec((32'h1 << (POS_MODEL_SPECIFIC_ERROR_FIELD + i)) | TYPE_B_CODE, !(i == BUS_ECC && sv), i == BUS_ECC && sv);
			end
		end
		$display("test bus done");
		for (int i = 0; i < 21; i++) begin
			send(MCBEC_KIND_CBC, i, i < 19);
			if (i < 19) begin
				check_rec({codes[i], TYPE_C_CODE}, codes[i][15:12] != 4'hc, codes[i][15:12] == 4'hc && sv);
			end
		end
		$display("test controller done");
		send(MCBEC_KIND_NONE, 0, 1'b0);
		send(MCBEC_KIND_LLC, 5, 1'b1);
		send(MCBEC_KIND_CBC, 0, 1'b0);
		check_rec({LLC_PATTERN, 2'b00, 3'h5, TYPE_A_CODE}, 1'b0, 1'b0);
		apb(1'b1, 12'h010, 32'hffff_ffff, 33'h0);
		apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
		apb(1'b0, OFS_EVENT, 32'h0, {1'b0, 32'(n_logged)});
		apb(1'b1, OFS_EVENT, 32'hffff_ffff, 33'h0);
		apb(1'b0, OFS_EVENT, 32'h0, {1'b0, 32'(n_logged)});
		apb(1'b1, OFS_STATUS_LO, 32'h1234_5678, 33'h0);
		apb(1'b0, OFS_STATUS_LO, 32'h0, {1'b0, 32'h1234_5678});
		apb(1'b1, OFS_CTRL, 32'h0, 33'h0);
		send(MCBEC_KIND_LLC, 1, 1'b0);
		$display("test refusals done");
		repeat (4) @(posedge pclk);
		if (read_q.size() != 0 || event_q.size() != 0) begin
			n_mismatch++;
		end
		stop_test();
	end
endmodule
